// >>> design/module_pins_pkg.sv
// constants, address map and state codes of the module control and management logic
package module_pins_pkg;

    // clock rate and timing figures
    localparam int CLOCK_MHZ        = 125;
    localparam int T_RESET_MIN_US   = 10;
    localparam int RESET_MIN_CYCLES = T_RESET_MIN_US * CLOCK_MHZ;
    localparam int T_INIT_MS        = 2000;
    localparam int INIT_CYCLES      = T_INIT_MS * 1000 * CLOCK_MHZ;

    // management bus address (A0h in 8-bit form)
    localparam logic [6:0] DEV_ADDR = 7'h50;

    // byte map of the lower page
    localparam int MEM_AW             = 7;
    localparam int MEM_DW             = 8;
    localparam logic [6:0] ADDR_IDENT  = 7'h00;
    localparam logic [6:0] ADDR_STAT1  = 7'h01;
    localparam logic [6:0] ADDR_STAT2  = 7'h02;
    localparam logic [6:0] ADDR_FLAGS  = 7'h03;
    localparam logic [6:0] ADDR_CTRL   = 7'h56;
    localparam logic [6:0] ADDR_LOGIC_END = 7'h04;

    // identifier byte, value arbitrary
    localparam logic [7:0] IDENT_VALUE = 8'h5A;

    // field positions
    localparam int STAT1_LPM_BIT   = 0;
    localparam int STAT2_DNR_BIT   = 0;
    localparam int STAT2_INT_BIT   = 1;
    localparam int FLAG_RESET_BIT  = 0;
    localparam int FLAG_FAULT_BIT  = 1;

    // reset values
    localparam logic [7:0] SETTING_DEFAULT = 8'h00;
    localparam logic [4:0] SYNC_RESET      = 5'h0F;

    // 2-wire slave states
    typedef enum logic [3:0] {
        ST_IDLE      = 4'b0000,
        ST_ADDR      = 4'b0001,
        ST_ACK_ADDR  = 4'b0010,
        ST_PTR       = 4'b0011,
        ST_ACK_PTR   = 4'b0100,
        ST_WDATA     = 4'b0101,
        ST_ACK_W     = 4'b0110,
        ST_RDATA     = 4'b0111,
        ST_ACK_R     = 4'b1000
    } wire_state_t;

endpackage

// >>> design/settings_mem.sv
// byte memory of the management page with registered read data
module settings_mem (
    input  wire logic                                 clock,  // system clock
    input  wire logic                                 we,     // write strobe
    input  wire logic [module_pins_pkg::MEM_AW-1:0]   waddr,  // write address
    input  wire logic [module_pins_pkg::MEM_DW-1:0]   wdata,  // write data
    input  wire logic [module_pins_pkg::MEM_AW-1:0]   raddr,  // read address
    output logic      [module_pins_pkg::MEM_DW-1:0]   rdata   // read data, registered
);
    import module_pins_pkg::*;

    logic [MEM_DW-1:0] store [0:(1<<MEM_AW)-1];

    // write port and registered read port
    always_ff @(posedge clock) begin
        if (we) begin
            store[waddr] <= wdata;
        end
        rdata <= store[raddr];
    end

endmodule

// >>> design/module_control_pins.sv
// control pins, reset sequencing, attention and 2-wire slave of the pluggable module
// Contract
// - answer 2-wire traffic while select is low
// - ignore 2-wire traffic while select is high
// - select defaults to deselected when undriven; the code has no pull-up and only resets the select synchroniser to deselected
// - long reset pulse restores all default settings
// - init interval starts at reset rising edge
// - completion raises attention with not-ready cleared
// - power-up raises completion attention without reset
// - low-power request selects reduced power state
// - presence output tied low while seated
// - attention low reports fault or critical status
// - attention is open-collector, pulled low only
// - respond at device address A0h
module module_control_pins #(
    parameter int INIT_COUNT = module_pins_pkg::INIT_CYCLES  // init interval in clock cycles
) (
    input  wire logic clock,              // system clock, 125 MHz
    input  wire logic rst,                // synchronous reset, power-up
    input  wire logic module_select_n,    // select pin, low selects
    input  wire logic module_reset_n,     // reset pin, low resets
    input  wire logic low_power_request,  // low-power pin, high requests
    input  wire logic scl,                // 2-wire clock pin
    input  wire logic sda_in,             // 2-wire data pin level
    output logic      sda_out,            // 2-wire data drive value, always low
    output logic      sda_oe,             // 2-wire data pulled low when high
    output logic      attention_n_out,    // attention drive value, always low
    output logic      attention_n_oe,     // attention pulled low when high
    output logic      presence_n,         // presence, low when seated
    output logic      low_power_mode,     // reduced power state enable
    input  wire logic fault_event         // internal fault pulse, same clock
);
    import module_pins_pkg::*;

    // synchroniser bit order: {lpm, select_n, reset_n, scl, sda}
    logic [4:0]        sync1_reg;
    logic [4:0]        sync2_reg;
    logic              scl_prev_reg;
    logic              sda_prev_reg;
    logic              rstn_prev_reg;
    logic [31:0]       low_count_reg;
    logic              init_busy_reg;
    logic [31:0]       init_count_reg;
    logic              data_not_ready_reg;
    logic [MEM_AW-1:0] sweep_addr_reg;
    logic              sweep_busy_reg;
    logic [1:0]        flag_reg;
    wire_state_t       state_reg;
    logic [3:0]        bit_cnt_reg;
    logic [7:0]        shift_reg;
    logic [MEM_AW-1:0] ptr_reg;
    logic              rw_reg;
    logic              ack_reg;
    logic              sda_oe_reg;

    wire logic        scl_s;
    wire logic        sda_s;
    wire logic        rstn_s;
    wire logic        seln_s;
    wire logic        lpm_s;
    wire logic        selected;
    wire logic        scl_rise;
    wire logic        scl_fall;
    wire logic        start_det;
    wire logic        stop_det;
    wire logic        rst_rise;
    wire logic        long_low;
    wire logic        init_done;
    wire logic        byte_full;
    wire logic        addr_match;
    wire logic        host_write;
    wire logic        load_byte;
    wire logic        flags_read;
    wire logic        mem_we;
    wire logic [6:0]  mem_waddr;
    wire logic [7:0]  mem_wdata;
    wire logic [7:0]  mem_rdata;
    wire logic [7:0]  logic_byte;
    wire logic [7:0]  read_byte;

    // synchronised pin levels
    assign sda_s  = sync2_reg[0];
    assign scl_s  = sync2_reg[1];
    assign rstn_s = sync2_reg[2];
    assign seln_s = sync2_reg[3];
    assign lpm_s  = sync2_reg[4];

    // pin synchronisers, two stages each
    // select pin starts deselected
    always_ff @(posedge clock) begin
        if (rst) begin
            sync1_reg <= SYNC_RESET;
            sync2_reg <= SYNC_RESET;
        end else begin
            sync1_reg <= {low_power_request, module_select_n, module_reset_n, scl, sda_in};
            sync2_reg <= sync1_reg;
        end
    end

    // edge and bus condition decode
    assign selected  = ~seln_s;
    assign scl_rise  = scl_s & ~scl_prev_reg;
    assign scl_fall  = ~scl_s & scl_prev_reg;
    assign start_det = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
    assign stop_det  = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;
    assign rst_rise  = rstn_s & ~rstn_prev_reg;
    assign long_low  = low_count_reg > 32'(RESET_MIN_CYCLES);
    assign init_done = init_busy_reg && (init_count_reg >= 32'(INIT_COUNT - 1));

    // previous levels for edge detection
    always_ff @(posedge clock) begin
        if (rst) begin
            scl_prev_reg  <= 1'b1;
            sda_prev_reg  <= 1'b1;
            rstn_prev_reg <= 1'b1;
        end else begin
            scl_prev_reg  <= scl_s;
            sda_prev_reg  <= sda_s;
            rstn_prev_reg <= rstn_s;
        end
    end

    // width of the low pulse on the reset pin, saturating
    always_ff @(posedge clock) begin
        if (rst || rstn_s) begin
            low_count_reg <= 32'h00000000;
        end else if (!long_low) begin
            low_count_reg <= low_count_reg + 32'h00000001;
        end
    end

    // init interval: from power-up or from release of a long reset pulse
    // init sequencing
    always_ff @(posedge clock) begin
        if (rst) begin
            init_busy_reg      <= 1'b1;
            init_count_reg     <= 32'h00000000;
            data_not_ready_reg <= 1'b1;
        end else if (rst_rise && long_low) begin
            init_busy_reg      <= 1'b1;
            init_count_reg     <= 32'h00000000;
            data_not_ready_reg <= 1'b1;
        end else if (init_done) begin
            init_busy_reg      <= 1'b0;
            data_not_ready_reg <= 1'b0;
        end else if (init_busy_reg) begin
            init_count_reg <= init_count_reg + 32'h00000001;
        end
    end

    // settings sweep: every byte back to its default at init start
    // restore defaults
    always_ff @(posedge clock) begin
        if (rst || (rst_rise && long_low)) begin
            sweep_busy_reg <= 1'b1;
            sweep_addr_reg <= 7'h00;
        end else if (sweep_busy_reg) begin
            sweep_addr_reg <= sweep_addr_reg + 7'h01;
            sweep_busy_reg <= (sweep_addr_reg != 7'h7F);
        end
    end

    // sticky attention flags, a set beats a clear in the same cycle
    // attention sources
    always_ff @(posedge clock) begin
        if (rst) begin
            flag_reg <= 2'h0;
        end else begin
            flag_reg[FLAG_RESET_BIT] <= init_done | (flag_reg[FLAG_RESET_BIT] & ~flags_read);
            flag_reg[FLAG_FAULT_BIT] <= fault_event | (flag_reg[FLAG_FAULT_BIT] & ~flags_read);
        end
    end

    // byte decode of the 2-wire slave
    assign byte_full  = bit_cnt_reg == 4'h8;
    assign addr_match = shift_reg[7:1] == DEV_ADDR;
    assign host_write = (state_reg == ST_WDATA) && scl_fall && byte_full && (ptr_reg >= ADDR_CTRL);
    assign load_byte  = scl_fall && (((state_reg == ST_ACK_ADDR) && rw_reg) || ((state_reg == ST_ACK_R) && ack_reg));
    assign flags_read = load_byte && (ptr_reg == ADDR_FLAGS);

    // memory port steering, the sweep owns the write port for its 128 cycles at init start
    assign mem_we    = sweep_busy_reg | host_write;
    assign mem_waddr = sweep_busy_reg ? sweep_addr_reg : ptr_reg;
    assign mem_wdata = sweep_busy_reg ? SETTING_DEFAULT : shift_reg;

    // bytes produced by logic rather than memory
    assign logic_byte = (ptr_reg == ADDR_IDENT) ? IDENT_VALUE :
                        (ptr_reg == ADDR_STAT1) ? {7'h00, lpm_s} :
                        (ptr_reg == ADDR_STAT2) ? {6'h00, |flag_reg, data_not_ready_reg} :
                        {6'h00, flag_reg};
    assign read_byte  = (ptr_reg < ADDR_LOGIC_END) ? logic_byte : mem_rdata;

    settings_mem u_mem (
        .clock (clock),
        .we    (mem_we),
        .waddr (mem_waddr),
        .wdata (mem_wdata),
        .raddr (ptr_reg),
        .rdata (mem_rdata)
    );

    // 2-wire slave: bits sampled on scl rise, driven on scl fall
    // selection and addressing
    always_ff @(posedge clock) begin
        if (rst || !selected || stop_det) begin
            state_reg   <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            sda_oe_reg  <= 1'b0;
        end else if (start_det) begin
            state_reg   <= ST_ADDR;
            bit_cnt_reg <= 4'h0;
            sda_oe_reg  <= 1'b0;
        end else if (scl_rise) begin
            if (state_reg == ST_ADDR || state_reg == ST_PTR || state_reg == ST_WDATA) begin
                shift_reg   <= {shift_reg[6:0], sda_s};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (state_reg == ST_ACK_R) begin
                ack_reg <= ~sda_s;
            end
        end else if (scl_fall) begin
            case (state_reg)
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    if (byte_full) begin
                        bit_cnt_reg <= 4'h0;
                        if (state_reg == ST_ADDR && !addr_match) begin
                            state_reg <= ST_IDLE;
                        end else begin
                            sda_oe_reg <= 1'b1;
                            state_reg  <= (state_reg == ST_ADDR) ? ST_ACK_ADDR :
                                          (state_reg == ST_PTR) ? ST_ACK_PTR : ST_ACK_W;
                            rw_reg     <= (state_reg == ST_ADDR) ? shift_reg[0] : rw_reg;
                            ptr_reg    <= (state_reg == ST_PTR) ? shift_reg[6:0] :
                                          (state_reg == ST_WDATA) ? ptr_reg + 7'h01 : ptr_reg;
                        end
                    end
                end
                ST_ACK_ADDR, ST_ACK_R: begin
                    if (load_byte) begin
                        shift_reg   <= {read_byte[6:0], 1'b0};
                        sda_oe_reg  <= ~read_byte[7];
                        ptr_reg     <= ptr_reg + 7'h01;
                        bit_cnt_reg <= 4'h1;
                        state_reg   <= ST_RDATA;
                    end else begin
                        sda_oe_reg <= 1'b0;
                        state_reg  <= (state_reg == ST_ACK_ADDR) ? ST_PTR : ST_IDLE;
                    end
                end
                ST_ACK_PTR, ST_ACK_W: begin
                    sda_oe_reg <= 1'b0;
                    state_reg  <= ST_WDATA;
                end
                ST_RDATA: begin
                    if (byte_full) begin
                        sda_oe_reg <= 1'b0;
                        state_reg  <= ST_ACK_R;
                    end else begin
                        sda_oe_reg  <= ~shift_reg[7];
                        shift_reg   <= {shift_reg[6:0], 1'b0};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // pin outputs
    // open-collector pins only ever pull low
    assign sda_out         = 1'b0;
    assign sda_oe          = sda_oe_reg;
    assign attention_n_out = 1'b0;
    assign attention_n_oe  = |flag_reg;
    assign presence_n      = 1'b0;
    assign low_power_mode  = lpm_s;

    // checks on the pin behaviour
    chk_presence_grounded: assert property (@(posedge clock) disable iff (rst)
        presence_n == 1'b0) else $error("presence output not low");

    chk_open_drain_pins: assert property (@(posedge clock) disable iff (rst)
        !sda_out && !attention_n_out) else $error("open-drain pin drives high");

    chk_deselect_quiet_bus: assert property (@(posedge clock) disable iff (rst)
        !selected |=> !sda_oe && state_reg == ST_IDLE) else $error("deselected module touches bus");

    chk_select_reset_default: assert property (@(posedge clock) disable iff (rst)
        $fell(rst) |-> !selected && state_reg == ST_IDLE) else $error("select not deselected after reset");

    chk_address_ack_drive: assert property (@(posedge clock) disable iff (rst)
        (selected && state_reg == ST_ADDR && scl_fall && byte_full && addr_match && !start_det && !stop_det)
        |=> sda_oe && state_reg == ST_ACK_ADDR) else $error("own address not acknowledged");

    chk_foreign_address_ignored: assert property (@(posedge clock) disable iff (rst)
        (state_reg == ST_ADDR && scl_fall && byte_full && !addr_match) |=> !sda_oe)
        else $error("foreign address acknowledged");

    chk_long_reset_init: assert property (@(posedge clock) disable iff (rst)
        (rst_rise && long_low) |=> init_busy_reg && init_count_reg == 32'h0 && data_not_ready_reg && sweep_busy_reg)
        else $error("long reset pulse did not start init");

    chk_short_pulse_ignored: assert property (@(posedge clock) disable iff (rst)
        (rst_rise && !long_low && !init_busy_reg) |=> !init_busy_reg && !sweep_busy_reg)
        else $error("short reset pulse started init");

    chk_done_raises_attention: assert property (@(posedge clock) disable iff (rst)
        $fell(init_busy_reg) |-> !data_not_ready_reg && attention_n_oe) else $error("completion not signalled");

    chk_powerup_init: assert property (@(posedge clock) disable iff (rst)
        $fell(rst) |-> init_busy_reg && data_not_ready_reg) else $error("power-up init not started");

    chk_fault_attention: assert property (@(posedge clock) disable iff (rst)
        fault_event |=> attention_n_oe [*2]) else $error("fault did not hold attention");

    chk_low_power_follow: assert property (@(posedge clock) disable iff (rst)
        $rose(low_power_request) ##1 low_power_request ##1 low_power_request |=> low_power_mode)
        else $error("low power request not applied");

    chk_defaults_restored: assert property (@(posedge clock) disable iff (rst)
        (sweep_busy_reg && !$past(sweep_busy_reg)) |-> mem_we && mem_wdata == SETTING_DEFAULT)
        else $error("defaults not written on reset");

endmodule

// >>> bench/host_model.sv
// host side 2-wire master that drives clock and data of the management bus
module host_model (
    input  wire logic clock,    // system clock
    input  wire logic sda,      // resolved data wire
    output logic      scl,      // 2-wire clock, stands high outside frames
    output logic      sda_low   // host pulls data low when high
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus: clock high, data released
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    // one bit out: data changes only while the clock is low, 64 ns per bit
    task automatic put_bit(input logic b);
        scl <= 1'b0;
        tick(1);
        sda_low <= ~b;
        tick(3);
        scl <= 1'b1;
        tick(4);
    endtask

    // one bit in: data released, sampled late in the high phase
    task automatic get_bit(output logic b);
        scl <= 1'b0;
        tick(1);
        sda_low <= 1'b0;
        tick(3);
        scl <= 1'b1;
        tick(3);
        b = sda;
        tick(1);
    endtask

    // start: data falls while the clock is high
    task automatic start_cond();
        tick(2);
        sda_low <= 1'b1;
        tick(4);
    endtask

    // repeated start needs data high again before the falling data edge
    task automatic restart_cond();
        put_bit(1'b1);
        start_cond();
    endtask

    // stop: data rises while the clock is high, then the bus idles
    task automatic stop_cond();
        put_bit(1'b0);
        sda_low <= 1'b0;
        tick(8);
    endtask

    // byte out msb first, returns the acknowledge level (0 = acked)
    task automatic send_byte(input logic [7:0] v, output logic ack_n);
        for (int i = 7; i >= 0; i--) put_bit(v[i]);
        get_bit(ack_n);
    endtask

    // byte in msb first, then acknowledge or not-acknowledge on the last byte
    task automatic recv_byte(input logic last, output logic [7:0] v);
        for (int i = 7; i >= 0; i--) get_bit(v[i]);
        put_bit(last);
    endtask
endmodule

// >>> bench/tb_module_control_pins.sv
// self-checking bench of the module control pins against a behavioural model
module tb_module_control_pins;
    timeunit 1ns;
    timeprecision 1ps;
    import module_pins_pkg::*;

    localparam int INIT_N = 2000;  // shortened init interval

    logic       clock = 1'b0, rst = 1'b1, fault_event = 1'b0;
    logic       module_select_n = 1'b1, module_reset_n = 1'b1, low_power_request = 1'b0;
    logic       scl, sda_low, sda_out, sda_oe, att_out, att_oe, presence_n, low_power_mode;
    logic [7:0] mem_m [128];
    logic       lpm_m = 1'b0, dnr_m = 1'b0;
    logic [1:0] flags_m = 2'h0;
    int         num_errors = 0, n_tests = 0, cycles = 0, t0;
    int         addrs [$];
    logic [7:0] d;

    // wired-and bus with board pull-ups on data and attention
    wire logic sda_wire    = !((sda_oe && !sda_out) || sda_low);
    wire logic attention_n = !(att_oe && !att_out);

    always #4 clock = ~clock;

    module_control_pins #(.INIT_COUNT(INIT_N)) dut_u (
        .clock(clock), .rst(rst), .module_select_n(module_select_n),
        .module_reset_n(module_reset_n), .low_power_request(low_power_request),
        .scl(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
        .attention_n_out(att_out), .attention_n_oe(att_oe), .presence_n(presence_n),
        .low_power_mode(low_power_mode), .fault_event(fault_event));

    host_model host_u (.clock(clock), .sda(sda_wire), .scl(scl), .sda_low(sda_low));

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            num_errors++;
            stop_test();
        end
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // model of what each byte of the page should read
    function automatic logic [7:0] expect_byte(input int a);
        case (a)
            0: return IDENT_VALUE;
            1: return {7'h00, lpm_m};
            2: return {6'h00, flags_m != 2'h0, dnr_m};
            3: return {6'h00, flags_m};
            default: return mem_m[a];
        endcase
    endfunction

    // pointer then data, exp_ack is the set of missing acknowledges
    task automatic write_byte(input int a, input logic [7:0] v, input logic [7:0] exp_ack, input logic [7:0] dev);
        logic k0, k1, k2;
        host_u.start_cond();
        host_u.send_byte(dev, k0);
        host_u.send_byte({1'b0, a[6:0]}, k1);
        host_u.send_byte(v, k2);
        host_u.stop_cond();
        check("write ack", exp_ack, {5'h00, k0, k1, k2});
        if (exp_ack == 8'h00 && a >= int'(ADDR_CTRL)) mem_m[a] = v;
    endtask

    // pointer write, repeated start, one byte read with not-acknowledge
    task automatic read_byte(input int a);
        logic       k0, k1, k2;
        logic [7:0] v;
        host_u.start_cond();
        host_u.send_byte(8'hA0, k0);
        host_u.send_byte({1'b0, a[6:0]}, k1);
        host_u.restart_cond();
        host_u.send_byte(8'hA1, k2);
        host_u.recv_byte(1'b1, v);
        host_u.stop_cond();
        check("read ack", 8'h00, {5'h00, k0, k1, k2});
        check($sformatf("byte %0d", a), expect_byte(a), v);
        if (a == 3) flags_m = 2'h0;
    endtask

    // waits for attention and checks the cycles elapsed since t_start
    task automatic wait_attention(input int t_start, input int lo, input int hi, input string what);
        while (attention_n !== 1'b0 && cycles - t_start < hi + 8) @(posedge clock);
        check(what, 8'h01, {7'h00, (cycles - t_start >= lo) && (cycles - t_start <= hi)});
    endtask

    task automatic read_all();
        foreach (addrs[i]) read_byte(addrs[i]);
    endtask

    initial begin
        void'($urandom(32'hA9EA));
        foreach (mem_m[i]) mem_m[i] = 8'h00;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        module_select_n <= 1'b0;
        @(posedge clock);
        t0 = cycles;
        check("presence", 8'h00, {7'h00, presence_n});
        wait_attention(t0, INIT_N - 2, INIT_N + 4, "power-up attention");
        check("attention drive", 8'h00, {7'h00, att_out});
        flags_m = 2'h1;
        read_byte(2);
        read_byte(3);
        check("attention released", 8'h01, {7'h00, attention_n});
        $display("test power-up done");

        read_byte(0);
        write_byte(int'(ADDR_CTRL), 8'h3C, 8'h07, 8'hA2);
        module_select_n <= 1'b1;
        write_byte(int'(ADDR_CTRL), 8'hC3, 8'h07, 8'hA0);
        module_select_n <= 1'b0;
        repeat (4) @(posedge clock);
        addrs = '{4, 'h55, 'h56, 'h7F};
        repeat (4) addrs.push_back($urandom_range(int'(ADDR_CTRL), 127));
        foreach (addrs[i]) write_byte(addrs[i], 8'($urandom_range(1, 255)), 8'h00, 8'hA0);
        read_all();
        $display("test select and access done");

        repeat (4) begin
            lpm_m = 1'($urandom);
            low_power_request <= lpm_m;
            repeat (6) @(posedge clock);
            check("low power", {7'h00, lpm_m}, {7'h00, low_power_mode});
            read_byte(1);
        end
        $display("test low power done");

        module_reset_n <= 1'b0;
        repeat ($urandom_range(100, 1240)) @(posedge clock);
        module_reset_n <= 1'b1;
        repeat (INIT_N + 50) @(posedge clock);
        check("no init after short pulse", 8'h01, {7'h00, attention_n});
        read_all();
        $display("test short reset done");

        module_reset_n <= 1'b0;
        repeat (1300) @(posedge clock);
        module_reset_n <= 1'b1;
        t0 = cycles;
        foreach (mem_m[i]) mem_m[i] = 8'h00;
        dnr_m = 1'b1;
        repeat (200) @(posedge clock);
        read_byte(2);
        read_byte(addrs[2]);
        read_byte(addrs[3]);
        wait_attention(t0, INIT_N, INIT_N + 8, "reset completion");
        dnr_m = 1'b0;
        flags_m = 2'h1;
        read_byte(2);
        read_byte(3);
        read_all();
        $display("test long reset done");

        fault_event <= 1'b1;
        @(posedge clock);
        fault_event <= 1'b0;
        repeat (3) @(posedge clock);
        check("fault attention", 8'h00, {7'h00, attention_n});
        flags_m = 2'h2;
        read_byte(2);
        read_byte(3);
        check("fault released", 8'h01, {7'h00, attention_n});
        $display("test fault done");
        stop_test();
    end
endmodule
